/* cpu_mode_pkg.sv */
package cpu_mode_pkg;

    // ****************************************
    // operating mode states
    // ****************************************
    typedef enum logic [5:0] {
        ST_REAL    = 6'h01,
        ST_PROT    = 6'h02,
        ST_COMPAT  = 6'h04,
        ST_LONG64  = 6'h08,
        ST_SMM     = 6'h10,
        ST_RESUME  = 6'h20
    } mode_state_t;

    // ****************************************
    // address and operand size codes
    // ****************************************
    typedef enum logic [1:0] {
        SZ_8  = 2'h0,
        SZ_16 = 2'h1,
        SZ_32 = 2'h2,
        SZ_64 = 2'h3
    } size_t;

    // ****************************************
    // register file shape
    // ****************************************
    localparam logic [4:0] GP_COUNT_LEGACY = 5'h08;
    localparam logic [4:0] GP_COUNT_EXT = 5'h10;
    localparam logic [6:0] GP_WIDTH_LEGACY = 7'h20;
    localparam logic [6:0] GP_WIDTH_EXT = 7'h40;
    localparam logic [4:0] VEC_COUNT_LEGACY = 5'h08;
    localparam logic [4:0] VEC_COUNT_EXT = 5'h10;

    // ****************************************
    // saved context layout and storage
    // ****************************************
    localparam int IP_W = 32;
    localparam int CTX_IP_LSB = 0;
    localparam int CTX_BIG_BIT = IP_W;
    localparam int CTX_LONG_BIT = IP_W + 1;
    localparam int CTX_EMUL_BIT = IP_W + 2;
    localparam int CTX_STATE_LSB = IP_W + 3;
    localparam int CTX_W = IP_W + 9;
    localparam int CTX_DEPTH = 2;
    localparam logic [0:0] CTX_SLOT_SMM = 1'h0;

    // ****************************************
    // values after reset
    // ****************************************
    localparam mode_state_t RESET_STATE = ST_REAL;
    localparam logic [IP_W-1:0] RESET_IP = 32'h0000_0000;

endpackage : cpu_mode_pkg

/* pin_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_out
);

    // ****************************************
    // two-stage synchroniser
    // ****************************************
    logic stage1_q;
    logic stage1_d;
    logic stage2_q;
    logic stage2_d;

    always_comb begin
        stage1_d = async_in;
        stage2_d = stage1_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stage1_q <= RESET_LEVEL;
            stage2_q <= RESET_LEVEL;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign sync_out = stage2_q;

endmodule : pin_sync2

`default_nettype wire

/* context_store.sv */
`timescale 1ns/1ps
`default_nettype none

module context_store #(
    parameter int WIDTH = 41,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);

    // ****************************************
    // storage with registered read
    // ****************************************
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule : context_store

`default_nettype wire

/* cpu_operating_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - reset always lands in real mode
// - pin or controller message enters management mode
// - entry saves context: mode, segment bits and instruction pointer
// - return restores saved context exactly
// - legacy emulation is per-task protected attribute
// - code segment picks compatibility or 64-bit
// - compatibility: 4 GByte linear, 16/32 sizes
// - compatibility: no emulation, no task switching
// - compatibility keeps physical address extension
// - 64-bit defaults: address 64, operand 32
// - 64-bit: 16 registers, 64 bits wide
// - 64-bit: extension prefix with wide bit sets 64-bit operand size
// - byte and word access in every mode
module cpu_operating_mode_control (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sys_mgmt_irq_pin_n,
    input wire logic sys_mgmt_interrupt,
    input wire logic sys_mgmt_resume,
    input wire logic mode_switch_req,
    input wire logic mode_switch_prot,
    input wire logic long_mode_enable,
    input wire logic physical_addr_extension,
    input wire logic code_seg_load,
    input wire logic code_seg_long,
    input wire logic code_seg_big,
    input wire logic task_switch,
    input wire logic task_legacy_emul,
    input wire logic [cpu_mode_pkg::IP_W-1:0] current_ip,
    input wire logic register_extension_prefix,
    input wire logic rex_wide,
    input wire logic opsize_override,
    input wire logic addrsize_override,
    input wire logic [3:0] reg_index,
    input wire cpu_mode_pkg::size_t access_width,
    output cpu_mode_pkg::mode_state_t mode_state_q,
    output logic long_mode_state_q,
    output logic system_management_mode_q,
    output logic legacy_emul_active_q,
    output logic hw_task_mgmt_ok_q,
    output logic all_priv_levels_q,
    output logic linear_limit_4g_q,
    output logic physical_addr_ext_q,
    output cpu_mode_pkg::size_t addr_size_q,
    output cpu_mode_pkg::size_t oper_size_q,
    output logic [4:0] gp_reg_count_q,
    output logic [6:0] gp_reg_width_q,
    output logic [4:0] vec_reg_count_q,
    output logic reg_index_ok_q,
    output logic access_width_ok_q,
    output logic resume_valid_q,
    output logic [cpu_mode_pkg::IP_W-1:0] resume_ip_q
);
    import cpu_mode_pkg::*;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic size_t flip_size(input logic big, input logic ovr);
        flip_size = (big ^ ovr) ? SZ_32 : SZ_16;
    endfunction : flip_size

    function automatic logic is_long(input mode_state_t st);
        is_long = (st == ST_COMPAT) || (st == ST_LONG64);
    endfunction : is_long

    function automatic logic is_protected(input mode_state_t st);
        is_protected = (st == ST_PROT) || is_long(st);
    endfunction : is_protected

    // ****************************************
    // interrupt pin synchroniser and event latch
    // ****************************************
    logic pin_sync_n, pin_prev_q, pin_prev_d;
    logic smi_pending_q, smi_pending_d, smi_event, smi_take;

    pin_sync2 #(
        .RESET_LEVEL(1'b1)
    ) u_pin_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(sys_mgmt_irq_pin_n),
        .sync_out(pin_sync_n)
    );

    // ****************************************
    // mode state and saved context
    // ****************************************
    mode_state_t state_d, ctx_state;
    logic emul_q, emul_d, cs_long_q, cs_long_d, cs_big_q, cs_big_d;
    logic ctx_wr_en, ctx_rd_en, resume_valid_d;
    logic [CTX_W-1:0] ctx_wr_data, ctx_rd_data;
    logic [IP_W-1:0] resume_ip_d, ctx_ip;

    context_store #(
        .WIDTH(CTX_W),
        .DEPTH(CTX_DEPTH)
    ) u_ctx (
        .clock(clock),
        .wr_en(ctx_wr_en),
        .wr_addr(CTX_SLOT_SMM),
        .wr_data(ctx_wr_data),
        .rd_en(ctx_rd_en),
        .rd_addr(CTX_SLOT_SMM),
        .rd_data_q(ctx_rd_data)
    );

    always_comb begin
        pin_prev_d = pin_sync_n;
        smi_event = (pin_prev_q && !pin_sync_n) || sys_mgmt_interrupt;
        smi_take = smi_pending_q && (mode_state_q != ST_SMM) && (mode_state_q != ST_RESUME);
        smi_pending_d = (smi_pending_q && !smi_take) || smi_event;
        ctx_state = mode_state_t'(ctx_rd_data[CTX_STATE_LSB +: 6]);
        ctx_ip = ctx_rd_data[CTX_IP_LSB +: IP_W];
        ctx_wr_data = {mode_state_q, emul_q, cs_long_q, cs_big_q, current_ip};
        ctx_wr_en = smi_take;
        ctx_rd_en = 1'b0;
        state_d = mode_state_q;
        emul_d = emul_q;
        cs_long_d = cs_long_q;
        cs_big_d = cs_big_q;
        resume_valid_d = 1'b0;
        resume_ip_d = resume_ip_q;
        if (smi_take) begin
            state_d = ST_SMM;
        end else begin
            unique case (mode_state_q)
                ST_REAL: begin
                    if (mode_switch_req && mode_switch_prot) begin
                        state_d = ST_PROT;
                    end
                end
                ST_PROT, ST_COMPAT, ST_LONG64: begin
                    if (mode_switch_req && !mode_switch_prot) begin
                        state_d = ST_REAL;
                    end else if (code_seg_load && long_mode_enable) begin
                        state_d = code_seg_long ? ST_LONG64 : ST_COMPAT;
                    end else if (code_seg_load) begin
                        state_d = ST_PROT;
                    end else if (is_long(mode_state_q) && !long_mode_enable) begin
                        state_d = ST_PROT;
                    end
                end
                ST_SMM: begin
                    if (sys_mgmt_resume) begin
                        ctx_rd_en = 1'b1;
                        state_d = ST_RESUME;
                    end
                end
                ST_RESUME: begin
                    state_d = ctx_state;
                    emul_d = ctx_rd_data[CTX_EMUL_BIT];
                    cs_long_d = ctx_rd_data[CTX_LONG_BIT];
                    cs_big_d = ctx_rd_data[CTX_BIG_BIT];
                    resume_ip_d = ctx_ip;
                    resume_valid_d = 1'b1;
                end
                default: begin
                    state_d = ST_REAL;
                end
            endcase
            if (code_seg_load && (mode_state_q != ST_SMM) && (mode_state_q != ST_RESUME)) begin
                cs_long_d = code_seg_long;
                cs_big_d = code_seg_big;
            end
            if (task_switch && (mode_state_q != ST_SMM) && (mode_state_q != ST_RESUME)) begin
                emul_d = task_legacy_emul;
            end
        end
        if (state_d != ST_PROT && state_d != ST_SMM && state_d != ST_RESUME) begin
            emul_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_state_q <= RESET_STATE;
            pin_prev_q <= 1'b1;
            smi_pending_q <= 1'b0;
            emul_q <= 1'b0;
            cs_long_q <= 1'b0;
            cs_big_q <= 1'b0;
            resume_valid_q <= 1'b0;
            resume_ip_q <= RESET_IP;
        end else begin
            mode_state_q <= state_d;
            pin_prev_q <= pin_prev_d;
            smi_pending_q <= smi_pending_d;
            emul_q <= emul_d;
            cs_long_q <= cs_long_d;
            cs_big_q <= cs_big_d;
            resume_valid_q <= resume_valid_d;
            resume_ip_q <= resume_ip_d;
        end
    end

    // ****************************************
    // derived execution environment
    // ****************************************
    logic long_mode_d, smm_d, emul_out_d, hw_task_d, priv_d, limit_d, pae_d;
    size_t addr_size_d, oper_size_d;
    logic [4:0] gp_count_d, vec_count_d;
    logic [6:0] gp_width_d;
    logic reg_ok_d, width_ok_d;

    always_comb begin
        long_mode_d = is_long(state_d);
        smm_d = (state_d == ST_SMM);
        emul_out_d = emul_d && (state_d == ST_PROT);
        hw_task_d = (state_d == ST_PROT);
        priv_d = is_protected(state_d);
        limit_d = (state_d == ST_COMPAT) || !is_long(state_d);
        pae_d = physical_addr_extension && is_protected(state_d);
        gp_count_d = GP_COUNT_LEGACY;
        gp_width_d = GP_WIDTH_LEGACY;
        vec_count_d = VEC_COUNT_LEGACY;
        reg_ok_d = !reg_index[3];
        width_ok_d = (access_width != SZ_64);
        unique case (state_d)
            ST_LONG64: begin
                addr_size_d = addrsize_override ? SZ_32 : SZ_64;
                if (register_extension_prefix && rex_wide) begin
                    oper_size_d = SZ_64;
                end else begin
                    oper_size_d = opsize_override ? SZ_16 : SZ_32;
                end
                gp_count_d = GP_COUNT_EXT;
                gp_width_d = GP_WIDTH_EXT;
                vec_count_d = VEC_COUNT_EXT;
                reg_ok_d = !reg_index[3] || register_extension_prefix;
                width_ok_d = (access_width != SZ_64)
                    || (register_extension_prefix && rex_wide);
            end
            ST_PROT, ST_COMPAT: begin
                addr_size_d = flip_size(cs_big_d, addrsize_override);
                oper_size_d = flip_size(cs_big_d, opsize_override);
            end
            ST_REAL, ST_SMM, ST_RESUME: begin
                addr_size_d = flip_size(1'b0, addrsize_override);
                oper_size_d = flip_size(1'b0, opsize_override);
            end
            default: begin
                addr_size_d = SZ_16;
                oper_size_d = SZ_16;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            long_mode_state_q <= 1'b0;
            system_management_mode_q <= 1'b0;
            legacy_emul_active_q <= 1'b0;
            hw_task_mgmt_ok_q <= 1'b0;
            all_priv_levels_q <= 1'b0;
            linear_limit_4g_q <= 1'b1;
            physical_addr_ext_q <= 1'b0;
            addr_size_q <= SZ_16;
            oper_size_q <= SZ_16;
            gp_reg_count_q <= GP_COUNT_LEGACY;
            gp_reg_width_q <= GP_WIDTH_LEGACY;
            vec_reg_count_q <= VEC_COUNT_LEGACY;
            reg_index_ok_q <= 1'b0;
            access_width_ok_q <= 1'b0;
        end else begin
            long_mode_state_q <= long_mode_d;
            system_management_mode_q <= smm_d;
            legacy_emul_active_q <= emul_out_d;
            hw_task_mgmt_ok_q <= hw_task_d;
            all_priv_levels_q <= priv_d;
            linear_limit_4g_q <= limit_d;
            physical_addr_ext_q <= pae_d;
            addr_size_q <= addr_size_d;
            oper_size_q <= oper_size_d;
            gp_reg_count_q <= gp_count_d;
            gp_reg_width_q <= gp_width_d;
            vec_reg_count_q <= vec_count_d;
            reg_index_ok_q <= reg_ok_d;
            access_width_ok_q <= width_ok_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_reset_real: assert property (@(posedge clock) disable iff (!rst_b)
        !$past(rst_b) |-> (mode_state_q == ST_REAL) && (oper_size_q == SZ_16))
        else $error("not in real mode after reset");
    a_smi_entry: assert property (@(posedge clock) disable iff (!rst_b)
        (smi_pending_q && mode_state_q != ST_SMM && mode_state_q != ST_RESUME)
        |=> (mode_state_q == ST_SMM) && system_management_mode_q)
        else $error("pending management interrupt not taken");
    a_ctx_save: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(system_management_mode_q) |-> $past(ctx_wr_en) && $past(mode_state_q) != ST_SMM)
        else $error("management mode entered without saving context");
    a_ctx_restore: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_state_q == ST_RESUME) |=> resume_valid_q
        && (mode_state_q == $past(ctx_state)) && (resume_ip_q == $past(ctx_ip)))
        else $error("context not restored on return");
    a_emul_scope: assert property (@(posedge clock) disable iff (!rst_b)
        legacy_emul_active_q |-> (mode_state_q == ST_PROT) && hw_task_mgmt_ok_q)
        else $error("legacy emulation outside protected mode");
    a_cs_select: assert property (@(posedge clock) disable iff (!rst_b)
        (code_seg_load && long_mode_enable && !mode_switch_req && !smi_pending_q
        && is_protected(mode_state_q))
        |=> (mode_state_q == ($past(code_seg_long) ? ST_LONG64 : ST_COMPAT)))
        else $error("sub-mode not taken from code segment");
    a_compat_env: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_state_q == ST_COMPAT) |-> linear_limit_4g_q && (addr_size_q != SZ_64)
        && (oper_size_q != SZ_64) && !hw_task_mgmt_ok_q && all_priv_levels_q)
        else $error("compatibility environment wrong");
    a_compat_pae: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_state_q == ST_COMPAT) |-> (physical_addr_ext_q == $past(physical_addr_extension)))
        else $error("address extension lost in compatibility mode");
    a_64_default: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_state_q == ST_LONG64) && !$past(register_extension_prefix)
        && !$past(opsize_override) && !$past(addrsize_override)
        |-> (addr_size_q == SZ_64) && (oper_size_q == SZ_32))
        else $error("64-bit default sizes wrong");
    a_64_regs: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_state_q == ST_LONG64) |-> (gp_reg_count_q == GP_COUNT_EXT)
        && (gp_reg_width_q == GP_WIDTH_EXT) && (vec_reg_count_q == VEC_COUNT_EXT))
        else $error("64-bit register file shape wrong");
    a_rex_wide: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_state_q == ST_LONG64) && $past(register_extension_prefix) && $past(rex_wide)
        |-> (oper_size_q == SZ_64) && access_width_ok_q)
        else $error("extension prefix did not select 64-bit operand");
    a_subreg_ok: assert property (@(posedge clock) disable iff (!rst_b)
        ((access_width == SZ_8) || (access_width == SZ_16)) |=> access_width_ok_q)
        else $error("byte or word access refused");

endmodule : cpu_operating_mode_control

`default_nettype wire

/* mgmt_irq_source.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// management interrupt sources: pin and controller message
// ****************************************
module mgmt_irq_source (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic pin_fire,
    input wire logic msg_fire,
    output logic pin_n,
    output logic msg_pulse
);
    logic [2:0] low_cnt_q = 3'h0;
    logic msg_q = 1'b0;

    // pin held low four cycles, pulled high when released
    always @(posedge clock) begin
        if (!rst_b) begin
            low_cnt_q <= 3'h0;
            msg_q <= 1'b0;
        end else begin
            msg_q <= msg_fire;
            if (pin_fire) begin
                low_cnt_q <= 3'h4;
            end else if (low_cnt_q != 3'h0) begin
                low_cnt_q <= low_cnt_q - 3'h1;
            end
        end
    end

    assign pin_n = (low_cnt_q == 3'h0);
    assign msg_pulse = msg_q;

endmodule : mgmt_irq_source

`default_nettype wire

/* cpu_operating_mode_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module cpu_operating_mode_control_bench;
    import cpu_mode_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic sys_mgmt_resume = 1'b0, mode_switch_req = 1'b0, mode_switch_prot = 1'b0;
    logic long_mode_enable = 1'b0, physical_addr_extension = 1'b0, code_seg_load = 1'b0;
    logic code_seg_long = 1'b0, code_seg_big = 1'b0, task_switch = 1'b0;
    logic task_legacy_emul = 1'b0, register_extension_prefix = 1'b0, rex_wide = 1'b0;
    logic opsize_override = 1'b0, addrsize_override = 1'b0, pin_fire = 1'b0, msg_fire = 1'b0;
    logic [31:0] current_ip = 32'h0000_0000;
    logic [3:0] reg_index = 4'h0;
    size_t access_width = SZ_8;
    wire logic sys_mgmt_irq_pin_n, sys_mgmt_interrupt;
    mode_state_t mode_state_q;
    size_t addr_size_q, oper_size_q;
    logic long_mode_state_q, system_management_mode_q, legacy_emul_active_q, hw_task_mgmt_ok_q;
    logic all_priv_levels_q, linear_limit_4g_q, physical_addr_ext_q, reg_index_ok_q;
    logic access_width_ok_q, resume_valid_q;
    logic [4:0] gp_reg_count_q, vec_reg_count_q;
    logic [6:0] gp_reg_width_q;
    logic [31:0] resume_ip_q;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    mgmt_irq_source irq_src (.clock, .rst_b, .pin_fire, .msg_fire,
        .pin_n(sys_mgmt_irq_pin_n), .msg_pulse(sys_mgmt_interrupt));

    cpu_operating_mode_control DUT (.clock, .rst_b, .sys_mgmt_irq_pin_n, .sys_mgmt_interrupt,
        .sys_mgmt_resume, .mode_switch_req, .mode_switch_prot, .long_mode_enable,
        .physical_addr_extension, .code_seg_load, .code_seg_long, .code_seg_big, .task_switch,
        .task_legacy_emul, .current_ip, .register_extension_prefix, .rex_wide, .opsize_override,
        .addrsize_override, .reg_index, .access_width, .mode_state_q, .long_mode_state_q,
        .system_management_mode_q, .legacy_emul_active_q, .hw_task_mgmt_ok_q, .all_priv_levels_q,
        .linear_limit_4g_q, .physical_addr_ext_q, .addr_size_q, .oper_size_q, .gp_reg_count_q,
        .gp_reg_width_q, .vec_reg_count_q, .reg_index_ok_q, .access_width_ok_q, .resume_valid_q,
        .resume_ip_q);

    // ****************************************
    // shared tasks
    // ****************************************
    task tick;
        @(posedge clock);
        #1;
    endtask : tick

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task seg(input logic lng, input logic big);
        code_seg_long = lng;
        code_seg_big = big;
        code_seg_load = 1'b1;
        tick;
        code_seg_load = 1'b0;
        tick;
    endtask : seg

    task sw(input logic prot);
        mode_switch_prot = prot;
        mode_switch_req = 1'b1;
        tick;
        mode_switch_req = 1'b0;
        tick;
    endtask : sw

    task tsk(input logic em);
        task_legacy_emul = em;
        task_switch = 1'b1;
        tick;
        task_switch = 1'b0;
        tick;
    endtask : tsk

    task wait_mgmt;
        for (int i = 0; i < 8 && system_management_mode_q !== 1'b1; i++) tick;
        chk("mgmt", 32'(system_management_mode_q), 32'h1);
        chk("state", 32'(mode_state_q), 32'(ST_SMM));
    endtask : wait_mgmt

    task do_resume(input mode_state_t ms, input logic [31:0] ip);
        sys_mgmt_resume = 1'b1;
        tick;
        sys_mgmt_resume = 1'b0;
        for (int i = 0; i < 8 && resume_valid_q !== 1'b1; i++) tick;
        chk("rv", 32'(resume_valid_q), 32'h1);
        chk("state", 32'(mode_state_q), 32'(ms));
        chk("rip", resume_ip_q, ip);
        chk("mgmt", 32'(system_management_mode_q), 32'h0);
        tick;
        chk("rv", 32'(resume_valid_q), 32'h0);
    endtask : do_resume

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        chk("state", 32'(mode_state_q), 32'(ST_REAL));
        chk("osz", 32'(oper_size_q), 32'(SZ_16));
        chk("asz", 32'(addr_size_q), 32'(SZ_16));
        chk("gpc", 32'(gp_reg_count_q), 32'h8);
        chk("gpw", 32'(gp_reg_width_q), 32'h20);
        for (int w = 0; w < 3; w++) begin
            access_width = size_t'(w);
            tick;
            chk("wok", 32'(access_width_ok_q), 32'h1);
        end
        seg(1'b1, 1'b1);
        chk("state", 32'(mode_state_q), 32'(ST_REAL));
    endtask : t_reset

    task t_prot;
        physical_addr_extension = 1'b1;
        sw(1'b1);
        chk("state", 32'(mode_state_q), 32'(ST_PROT));
        chk("hwt", 32'(hw_task_mgmt_ok_q), 32'h1);
        tsk(1'b1);
        chk("emul", 32'(legacy_emul_active_q), 32'h1);
        tsk(1'b0);
        chk("emul", 32'(legacy_emul_active_q), 32'h0);
        tsk(1'b1);
    endtask : t_prot

    task t_compat;
        long_mode_enable = 1'b1;
        seg(1'b0, 1'b1);
        chk("state", 32'(mode_state_q), 32'(ST_COMPAT));
        chk("lms", 32'(long_mode_state_q), 32'h1);
        chk("asz", 32'(addr_size_q), 32'(SZ_32));
        chk("osz", 32'(oper_size_q), 32'(SZ_32));
        chk("lim", 32'(linear_limit_4g_q), 32'h1);
        chk("emul", 32'(legacy_emul_active_q), 32'h0);
        chk("hwt", 32'(hw_task_mgmt_ok_q), 32'h0);
        chk("priv", 32'(all_priv_levels_q), 32'h1);
        chk("pext", 32'(physical_addr_ext_q), 32'h1);
        tsk(1'b1);
        chk("emul", 32'(legacy_emul_active_q), 32'h0);
        seg(1'b0, 1'b0);
        chk("asz", 32'(addr_size_q), 32'(SZ_16));
        chk("osz", 32'(oper_size_q), 32'(SZ_16));
    endtask : t_compat

    task t_long;
        seg(1'b1, 1'b0);
        chk("state", 32'(mode_state_q), 32'(ST_LONG64));
        chk("asz", 32'(addr_size_q), 32'(SZ_64));
        chk("osz", 32'(oper_size_q), 32'(SZ_32));
        chk("gpc", 32'(gp_reg_count_q), 32'h10);
        chk("gpw", 32'(gp_reg_width_q), 32'h40);
        chk("vcc", 32'(vec_reg_count_q), 32'h10);
        chk("lim", 32'(linear_limit_4g_q), 32'h0);
        reg_index = 4'hC;
        tick;
        chk("rok", 32'(reg_index_ok_q), 32'h0);
        register_extension_prefix = 1'b1;
        tick;
        chk("rok", 32'(reg_index_ok_q), 32'h1);
        rex_wide = 1'b1;
        access_width = SZ_64;
        tick;
        chk("osz", 32'(oper_size_q), 32'(SZ_64));
        chk("wok", 32'(access_width_ok_q), 32'h1);
        register_extension_prefix = 1'b0;
        rex_wide = 1'b0;
        opsize_override = 1'b1;
        tick;
        chk("osz", 32'(oper_size_q), 32'(SZ_16));
        chk("wok", 32'(access_width_ok_q), 32'h0);
        opsize_override = 1'b0;
        addrsize_override = 1'b1;
        tick;
        chk("asz", 32'(addr_size_q), 32'(SZ_32));
        addrsize_override = 1'b0;
        access_width = SZ_8;
        reg_index = 4'h0;
        seg(1'b0, 1'b1);
        chk("state", 32'(mode_state_q), 32'(ST_COMPAT));
        seg(1'b1, 1'b0);
    endtask : t_long

    task t_mgmt_msg;
        current_ip = 32'h1234_5678;
        msg_fire = 1'b1;
        tick;
        msg_fire = 1'b0;
        wait_mgmt;
        sw(1'b0);
        chk("state", 32'(mode_state_q), 32'(ST_SMM));
        do_resume(ST_LONG64, 32'h1234_5678);
    endtask : t_mgmt_msg

    task t_mgmt_pin;
        seg(1'b0, 1'b1);
        current_ip = 32'hA5A5_0F0F;
        pin_fire = 1'b1;
        tick;
        pin_fire = 1'b0;
        wait_mgmt;
        msg_fire = 1'b1;
        tick;
        msg_fire = 1'b0;
        repeat (3) tick;
        do_resume(ST_COMPAT, 32'hA5A5_0F0F);
        wait_mgmt;
        do_resume(ST_COMPAT, 32'hA5A5_0F0F);
    endtask : t_mgmt_pin

    task t_midreset;
        seg(1'b1, 1'b0);
        long_mode_enable = 1'b0;
        tick;
        chk("state", 32'(mode_state_q), 32'(ST_PROT));
        rst_b = 1'b0;
        tick;
        rst_b = 1'b1;
        chk("state", 32'(mode_state_q), 32'(ST_REAL));
        chk("asz", 32'(addr_size_q), 32'(SZ_16));
        chk("gpc", 32'(gp_reg_count_q), 32'h8);
        tick;
        chk("state", 32'(mode_state_q), 32'(ST_REAL));
        chk("osz", 32'(oper_size_q), 32'(SZ_16));
    endtask : t_midreset

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    // ****************************************
    // sequence and timeout
    // ****************************************
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            test_done;
        end
    end

    initial begin
        repeat (5) tick;
        rst_b = 1'b1;
        t_reset;
        t_prot;
        t_compat;
        t_long;
        t_mgmt_msg;
        t_mgmt_pin;
        t_midreset;
        test_done;
    end

endmodule : cpu_operating_mode_control_bench

`default_nettype wire
